// ==== src/lcdd_pkg.sv ====
package lcdd_pkg;
  // Clock and pin counts
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int NUM_PINS = 62;
  localparam int MAX_COM = 16;
  localparam int LVL_W = 3;
  // Refresh rate limits in Hz
  localparam logic [7:0] RATE_MIN = 8'h0a;
  localparam logic [7:0] RATE_MAX = 8'h96;
  localparam logic [7:0] RATE_RST = 8'h3c;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONTRAST = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_COM_LO = 8'h0c;
  localparam logic [7:0] OFS_COM_HI = 8'h10;
  localparam logic [7:0] OFS_PDATA_LO = 8'h14;
  localparam logic [7:0] OFS_PDATA_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Bias codes: static, then 1/2 up to 1/5
  localparam logic [2:0] BIAS_STATIC = 3'h1;
  localparam logic [2:0] BIAS_MAX = 3'h5;
  localparam logic [1:0] DRIVE_MAX = 2'h2;
  localparam logic [5:0] CONTRAST_RST = 6'h20;
  // Control register layout
  typedef struct packed {
    logic [3:0] ncom_m1;  // Commons minus one, bits 12:9
    logic lp_keep;        // Bit 8
    logic [1:0] drive;    // Bits 7:6
    logic invert;         // Bit 5
    logic wave_b;         // Bit 4
    logic [2:0] bias;     // Bits 3:1, levels above ground
    logic enable;         // Bit 0
  } lcdd_ctrl_type;
  localparam lcdd_ctrl_type CTRL_RST = '{ncom_m1: 4'h3, lp_keep: 1'b0, drive: 2'h0, invert: 1'b0,
                                        wave_b: 1'b0, bias: 3'h3, enable: 1'b0};
  // Global timing broadcast to every pin driver
  typedef struct packed {
    logic run;            // Drivers active
    logic pol;            // Drive polarity of this slot
    logic [2:0] bias;     // Top level code in use
  } lcdd_glob_type;
endpackage

// ==== src/lcdd_rate_gen.sv ====
`timescale 1ns/1ps
// Fractional accumulator: steps_i ticks per frame, rate_i frames per second
module lcdd_rate_gen import lcdd_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [7:0] rate_i,
  input wire logic [5:0] steps_i,
  output logic tick_o
);
  logic [23:0] acc_reg, acc_next;  // Phase accumulator
  logic tick_reg, tick_next;
  logic [23:0] inc;                // Ticks wanted per second
  logic [24:0] sum;

  // Avoids a divider: exact average rate, jitter of one clock
  always_comb begin
    inc = 24'(rate_i * steps_i);
    sum = {1'b0, acc_reg} + {1'b0, inc};
    acc_next = acc_reg;
    tick_next = 1'b0;
    if (!run_i) begin
      acc_next = '0;
    end else if (sum >= 25'(CLK_HZ)) begin
      acc_next = 24'(sum - 25'(CLK_HZ));
      tick_next = 1'b1;
    end else begin
      acc_next = sum[23:0];
    end
  end

  // State registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end
  assign tick_o = tick_reg;

  // Ticks are single pulses, never back to back at legal rates
  a_tick_single: assert property (@(posedge clk_sys_i) disable iff (srst_i) tick_o |=> !tick_o)
    else $error("rate tick lasted two cycles");
endmodule

// ==== src/lcdd_pin_drv.sv ====
`timescale 1ns/1ps
// One pin: picks a bias level from role, data and polarity
module lcdd_pin_drv import lcdd_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire lcdd_glob_type glob_i,
  input wire logic is_com_i,
  input wire logic com_sel_i,
  input wire logic pix_on_i,
  output logic [LVL_W-1:0] level_o
);
  logic [LVL_W-1:0] level_reg, level_next;
  logic [LVL_W-1:0] top;

  // Level choice; top is the bias count, ground is zero
  always_comb begin
    top = glob_i.bias;
    level_next = '0;
    if (!glob_i.run) begin
      level_next = '0;
    end else if (is_com_i) begin
      if (com_sel_i) begin
        level_next = glob_i.pol ? top : '0;
      end else begin
        level_next = glob_i.pol ? 3'h1 : 3'(top - 3'h1);
      end
    end else if (pix_on_i) begin
      level_next = glob_i.pol ? '0 : top;
    end else if (top == BIAS_STATIC) begin
      // Static: an off segment follows the backplane
      level_next = glob_i.pol ? top : '0;
    end else begin
      level_next = glob_i.pol ? 3'h2 : 3'(top - 3'h2);
    end
  end

  // Output register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end
  assign level_o = level_reg;

  a_level_bound: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    glob_i.run |=> level_o <= $past(glob_i.bias))
    else $error("pin level above selected bias");
  a_level_idle: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !glob_i.run |=> level_o == '0)
    else $error("idle pin not grounded");
endmodule

// ==== src/lcdd_seq.sv ====
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Segment LCD sequencer: APB registers, common scan, DMA row fetch, pin drivers
module lcdd_seq import lcdd_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic lp_active_i,
  output logic dma_req_o,
  output logic [3:0] dma_row_o,
  output logic [NUM_PINS-1:0] pin_is_com_o,
  output logic [NUM_PINS-1:0][LVL_W-1:0] lcd_level_o,
  output logic [2:0] bias_sel_o,
  output logic [5:0] contrast_o,
  output logic [1:0] drive_mode_o
);
  // Register file
  lcdd_ctrl_type ctrl_reg, ctrl_next;
  logic [5:0] contrast_reg, contrast_next;
  logic [7:0] rate_reg, rate_next;
  logic [NUM_PINS-1:0] com_reg, com_next;      // Per-pin role mask
  logic [NUM_PINS-1:0] stage_reg, stage_next;  // Port data registers
  logic [NUM_PINS-1:0] row_reg, row_next;      // Row on the glass now
  logic stage_ok_reg, stage_ok_next;           // Staged row is fresh
  logic underrun_reg, underrun_next;           // Sticky, write one to clear
  // Bus answer
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  // Scan state
  logic [3:0] cur_com_reg, cur_com_next;
  logic phase_reg, phase_next;                 // Standard wave: second half
  logic pol_reg, pol_next;
  logic run_reg, run_next;
  logic dma_req_reg, dma_req_next;
  logic [3:0] dma_row_reg, dma_row_next;
  // Helpers
  logic run_want;
  logic tick;
  logic [5:0] steps;
  logic [3:0] nxt_com;
  logic wr_en, rd_en;
  logic [6:0] rank [NUM_PINS+1];               // Commons below each pin
  logic [NUM_PINS-1:0] com_sel;
  lcdd_glob_type glob;

  // Rate value kept inside the legal refresh range
  function automatic logic [7:0] clamp_rate(input logic [7:0] r);
    if (r < RATE_MIN) begin
      clamp_rate = RATE_MIN;
    end else if (r > RATE_MAX) begin
      clamp_rate = RATE_MAX;
    end else begin
      clamp_rate = r;
    end
  endfunction

  // Address decode, shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction

  // Writes count once pready is up, reads in the access cycle before it; one wait state
  assign wr_en = psel_i && penable_i && pwrite_i && pready_reg && mapped(paddr_i);
  assign rd_en = psel_i && penable_i && !pwrite_i && !pready_reg;
  assign run_want = ctrl_reg.enable && (!lp_active_i || ctrl_reg.lp_keep);
  // Standard wave uses two slots per common, low power wave one
  assign steps = ctrl_reg.wave_b ? 6'({2'h0, ctrl_reg.ncom_m1} + 6'h1)
                                 : 6'(({2'h0, ctrl_reg.ncom_m1} + 6'h1) << 1);
  assign nxt_com = (cur_com_reg == ctrl_reg.ncom_m1) ? 4'h0 : 4'(cur_com_reg + 4'h1);

  // Rank of each common pin; commons past sixteen never get selected
  assign rank[0] = '0;
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    assign rank[i+1] = 7'(rank[i] + {6'h0, com_reg[i]});
    assign com_sel[i] = com_reg[i] && (rank[i] == {3'h0, cur_com_reg}) && (rank[i] < 7'(MAX_COM));
    lcdd_pin_drv u_drv (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .glob_i(glob),
      .is_com_i(com_reg[i]),
      .com_sel_i(com_sel[i]),
      .pix_on_i(row_reg[i] ^ ctrl_reg.invert),
      .level_o(lcd_level_o[i])
    );
  end

  // Broadcast timing to all pins
  assign glob = '{run: run_reg, pol: pol_reg, bias: ctrl_reg.bias};

  lcdd_rate_gen u_rate (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .run_i(run_reg),
    .rate_i(rate_reg),
    .steps_i(steps),
    .tick_o(tick)
  );

  // Register writes, bus answer and scan sequencing
  always_comb begin
    ctrl_next = ctrl_reg;
    contrast_next = contrast_reg;
    rate_next = rate_reg;
    com_next = com_reg;
    stage_next = stage_reg;
    row_next = row_reg;
    stage_ok_next = stage_ok_reg;
    underrun_next = underrun_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    cur_com_next = cur_com_reg;
    phase_next = phase_reg;
    pol_next = pol_reg;
    run_next = run_want;
    dma_req_next = dma_req_reg;
    dma_row_next = dma_row_reg;
    // Answer prepared in the first access cycle
    if (psel_i && penable_i && !pready_reg) begin
      pready_next = 1'b1;
      pslverr_next = !mapped(paddr_i);
    end
    if (rd_en) begin
      unique case (paddr_i)
        OFS_CTRL: prdata_next = {19'h0, ctrl_reg};
        OFS_CONTRAST: prdata_next = {26'h0, contrast_reg};
        OFS_RATE: prdata_next = {24'h0, rate_reg};
        OFS_COM_LO: prdata_next = com_reg[31:0];
        OFS_COM_HI: prdata_next = {2'h0, com_reg[NUM_PINS-1:32]};
        OFS_PDATA_LO: prdata_next = stage_reg[31:0];
        OFS_PDATA_HI: prdata_next = {2'h0, stage_reg[NUM_PINS-1:32]};
        OFS_STATUS: prdata_next = {17'h0, (rank[NUM_PINS] > 7'(MAX_COM)), rank[NUM_PINS][5:0],
                                   underrun_reg, dma_req_reg, pol_reg, cur_com_reg, run_reg};
        default: prdata_next = '0;
      endcase
    end
    if (wr_en) begin
      unique case (paddr_i)
        OFS_CTRL: begin
          ctrl_next = pwdata_i[12:0];
          // Illegal codes fall back to the nearest legal one
          if (pwdata_i[3:1] == 3'h0) begin
            ctrl_next.bias = BIAS_STATIC;
          end else if (pwdata_i[3:1] > BIAS_MAX) begin
            ctrl_next.bias = BIAS_MAX;
          end
          if (pwdata_i[7:6] > DRIVE_MAX) begin
            ctrl_next.drive = DRIVE_MAX;
          end
        end
        OFS_CONTRAST: contrast_next = pwdata_i[5:0];
        OFS_RATE: rate_next = clamp_rate(pwdata_i[7:0]);
        OFS_COM_LO: com_next[31:0] = pwdata_i;
        OFS_COM_HI: com_next[NUM_PINS-1:32] = pwdata_i[NUM_PINS-33:0];
        OFS_PDATA_LO: stage_next[31:0] = pwdata_i;
        OFS_PDATA_HI: begin
          // Upper word completes the row, so it acknowledges the DMA
          stage_next[NUM_PINS-1:32] = pwdata_i[NUM_PINS-33:0];
          stage_ok_next = 1'b1;
          dma_req_next = 1'b0;
        end
        OFS_STATUS: begin
          if (pwdata_i[7]) begin
            underrun_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (!run_reg) begin
      // Start as if at the last common so the first tick loads row 0
      cur_com_next = ctrl_reg.ncom_m1;
      phase_next = 1'b1;
      pol_next = 1'b0;
      dma_req_next = run_want;
      dma_row_next = 4'h0;
      if (run_want) begin
        stage_ok_next = 1'b0;
      end
    end else if (tick) begin
      if (!ctrl_reg.wave_b && !phase_reg) begin
        // Standard wave flips polarity inside each common slot
        phase_next = 1'b1;
        pol_next = 1'b1;
      end else begin
        phase_next = 1'b0;
        cur_com_next = nxt_com;
        if (!ctrl_reg.wave_b) begin
          pol_next = 1'b0;
        end else if (nxt_com == 4'h0) begin
          pol_next = !pol_reg;
        end
        if (stage_ok_reg || wr_en && paddr_i == OFS_PDATA_HI) begin
          row_next = stage_next;
          stage_ok_next = 1'b0;
          dma_req_next = 1'b1;
          dma_row_next = (nxt_com == ctrl_reg.ncom_m1) ? 4'h0 : 4'(nxt_com + 4'h1);
        end else begin
          // Row missed: the old row stays, the event is kept, set beats clear
          underrun_next = 1'b1;
        end
      end
    end
  end

  // All register state
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_reg <= CTRL_RST;
      contrast_reg <= CONTRAST_RST;
      rate_reg <= RATE_RST;
      com_reg <= '0;
      stage_reg <= '0;
      row_reg <= '0;
      stage_ok_reg <= 1'b0;
      underrun_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      cur_com_reg <= '0;
      phase_reg <= 1'b0;
      pol_reg <= 1'b0;
      run_reg <= 1'b0;
      dma_req_reg <= 1'b0;
      dma_row_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      contrast_reg <= contrast_next;
      rate_reg <= rate_next;
      com_reg <= com_next;
      stage_reg <= stage_next;
      row_reg <= row_next;
      stage_ok_reg <= stage_ok_next;
      underrun_reg <= underrun_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      cur_com_reg <= cur_com_next;
      phase_reg <= phase_next;
      pol_reg <= pol_next;
      run_reg <= run_next;
      dma_req_reg <= dma_req_next;
      dma_row_reg <= dma_row_next;
    end
  end

  // Outputs straight from registers
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign dma_req_o = dma_req_reg;
  assign dma_row_o = dma_row_reg;
  assign pin_is_com_o = com_reg;
  assign bias_sel_o = ctrl_reg.bias;
  assign contrast_o = contrast_reg;
  assign drive_mode_o = ctrl_reg.drive;

  // Two-step write: access phase waits, then completes
  sequence s_wr_hi;
    psel_i && penable_i && pwrite_i && !pready_o && paddr_i == OFS_PDATA_HI ##1 pready_o;
  endsequence
  sequence s_wr_contrast;
    psel_i && penable_i && pwrite_i && pready_o && paddr_i == OFS_CONTRAST;
  endsequence

  a_dma_ack: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    s_wr_hi |=> !dma_req_o)
    else $error("row write did not drop the DMA request");
  a_contrast_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    s_wr_contrast |=> contrast_o == $past(pwdata_i[5:0]))
    else $error("contrast not taken");
  a_pready_wait: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("APB answer not one cycle after one wait");
  a_one_common: assert property (@(posedge clk_sys_i) disable iff (srst_i) $onehot0(com_sel))
    else $error("more than one common selected");
  a_lp_halt: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    lp_active_i && !ctrl_reg.lp_keep ##1 lp_active_i |-> !run_reg)
    else $error("scan running in limited active state");
  a_rate_range: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rate_reg >= RATE_MIN && rate_reg <= RATE_MAX)
    else $error("refresh rate out of range");
  a_pol_flip_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    run_reg && tick && !ctrl_reg.wave_b && !phase_reg |=> pol_reg)
    else $error("standard wave did not flip polarity");
  a_req_on_tick: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    run_reg && tick && stage_ok_reg && (ctrl_reg.wave_b || phase_reg) |=> dma_req_o)
    else $error("no DMA request after row load");
endmodule

// ==== dv/lcdd_panel_model.sv ====
`timescale 1ns/1ps
// Passive glass: watches every pin level against the bias bus in use
module lcdd_panel_model import lcdd_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [NUM_PINS-1:0][LVL_W-1:0] lcd_level_i,
  input wire logic [2:0] bias_sel_i,
  output int err_cnt_o
);
  logic [2:0] bias_q;  // Bias in force when the levels were chosen
  // A level above the top bias line has no voltage to connect to
  // Levels lag the bias select by their own register stage
  always @(posedge clk_sys_i) begin
    bias_q <= bias_sel_i;
    if (srst_i) begin
      err_cnt_o <= 0;
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        // Six lines only, and no more than the bias allows
        if ((lcd_level_i[p] <= bias_q) !== 1'b1) begin
          err_cnt_o <= err_cnt_o + 1;
        end
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
// Self-checking bench: APB master, random stimulus, three ticks of scanning
module tb_top import lcdd_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lp_active = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, rv;
  logic pready, pslverr, err, dma_req;
  logic [3:0] dma_row;
  logic [NUM_PINS-1:0] pin_is_com;
  logic [NUM_PINS-1:0][LVL_W-1:0] lcd_level;
  logic [2:0] bias_sel, eb;
  logic [5:0] contrast;
  logic [1:0] drive_mode;
  logic [61:0] pix, mask;
  int mismatches = 0, compares = 0, panel_err;
  // 10 MHz system clock
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  lcdd_seq u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .lp_active_i(lp_active), .dma_req_o(dma_req), .dma_row_o(dma_row),
    .pin_is_com_o(pin_is_com), .lcd_level_o(lcd_level), .bias_sel_o(bias_sel),
    .contrast_o(contrast), .drive_mode_o(drive_mode));
  lcdd_panel_model u_panel (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .lcd_level_i(lcd_level),
    .bias_sel_i(bias_sel), .err_cnt_o(panel_err));
  // Verdict and end of run
  task automatic test_done();
    `CHK(panel_err, 0)
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; only the watchdog bounds the wait on pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Waits for the DMA request to come up; a tick can be ~33k cycles away
  task automatic wait_req();
    int n;
    n = 0;
    while (dma_req !== 1'b1 && n < 40000) begin
      @(posedge clk_sys_i);
      n++;
    end
    `CHK(dma_req, 1'b1)
  endtask
  // Expected pin level from role, selection, pixel and polarity
  function automatic logic [2:0] exp_lvl(input logic com, sel, on, pol, input logic [2:0] top);
    if (com) return sel ? (pol ? top : 3'h0) : (pol ? 3'h1 : top - 3'h1);
    return on ? (pol ? 3'h0 : top) : (pol ? 3'h2 : top - 3'h2);
  endfunction
  // Checks every pin after a tick; pin 0 is the only common
  task automatic check_pins(input logic pol, input logic inv, input logic sel);
    for (int p = 0; p < NUM_PINS; p++) begin
      `CHK(lcd_level[p], exp_lvl(p == 0, sel, pix[p] ^ inv, pol, 3'h3))
    end
  endtask
  // Hang guard at 90000 cycles, about a third beyond the ~67k cycles the three scan ticks need
  initial begin
    #(90000 * 100);
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(46));
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    // Reset values
    `CHK(bias_sel, 3'h3)
    `CHK(contrast, CONTRAST_RST)
    `CHK(dma_req, 1'b0)
    `CHK(pin_is_com, 62'h0)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0606)
    apb(1'b0, OFS_RATE, 32'h0);
    `CHK(rd, 32'h0000_003c)
    // Unmapped and unaligned places refuse
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h02, 32'hffff_ffff);
    `CHK(err, 1'b1)
    $display("test reset done");
    // Every bias and drive code; bias clamped at both ends, drive at the top
    for (int b = 0; b < 8; b++) begin
      apb(1'b1, OFS_CTRL, (b << 1) | ((b % 4) << 6));
      eb = (b == 0) ? 3'h1 : (b > 5) ? 3'h5 : 3'(b);
      `CHK(bias_sel, eb)
      `CHK(drive_mode, (b % 4 == 3) ? 2'h2 : 2'(b % 4))
    end
    // Random contrast, rate and role mask
    repeat (4) begin
      rv = $urandom;
      apb(1'b1, OFS_CONTRAST, rv);
      `CHK(contrast, rv[5:0])
      rv = $urandom_range(255, 0);
      apb(1'b1, OFS_RATE, rv);
      apb(1'b0, OFS_RATE, 32'h0);
      `CHK(rd[7:0], (rv < 10) ? 8'h0a : (rv > 150) ? 8'h96 : rv[7:0])
      mask = 62'({$urandom, $urandom});
      apb(1'b1, OFS_COM_LO, mask[31:0]);
      apb(1'b1, OFS_COM_HI, {2'b00, mask[61:32]});
      `CHK(pin_is_com, mask)
    end
    $display("test config done");
    // One common, fastest rate, bias 1/3, standard waveform
    apb(1'b1, OFS_COM_LO, 32'h1);
    apb(1'b1, OFS_COM_HI, 32'h0);
    apb(1'b1, OFS_RATE, 32'd150);
    apb(1'b1, OFS_CTRL, 32'h0007);
    wait_req();
    `CHK(dma_row, 4'h0)
    pix = 62'({$urandom, $urandom});
    apb(1'b1, OFS_PDATA_LO, pix[31:0]);
    `CHK(dma_req, 1'b1)
    apb(1'b1, OFS_PDATA_HI, {2'b00, pix[61:32]});
    `CHK(dma_req, 1'b0)
    wait_req();
    repeat (3) @(posedge clk_sys_i);
    `CHK(dma_row, 4'h0)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK({rd[13:8], rd[7:1]}, {6'h01, 7'h20})
    check_pins(1'b0, 1'b0, 1'b1);
    $display("test first tick done");
    // Inverted; two commons halve the tick spacing, pin 0 stays the only common
    apb(1'b1, OFS_CTRL, 32'h0227);
    apb(1'b0, OFS_STATUS, 32'h0);
    while (rd[5] !== 1'b1) begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end
    // Mid-slot flip is not a new common, so no underrun yet
    `CHK(rd[7], 1'b0)
    `CHK(rd[5], 1'b1)
    check_pins(1'b1, 1'b1, 1'b1);
    // Next tick moves to common 1 with no fresh row: old row kept
    while (rd[7] !== 1'b1) begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end
    `CHK(rd[6:1], 6'h21)
    check_pins(1'b0, 1'b1, 1'b0);
    apb(1'b1, OFS_STATUS, 32'h80);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[7], 1'b0)
    $display("test second tick done");
    // Limited active state stops the scan unless kept
    lp_active <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK({rd[0], dma_req}, 2'b00)
    apb(1'b1, OFS_CTRL, 32'h0337);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0337)
    $display("test low power done");
    test_done();
  end
endmodule
